/* hw/rbc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module rbc_top #(
  parameter int HOLD_CYC = rbc_pkg::RST_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_on_reset_in_n,
  input wire logic host_mode_strap,
  input wire logic [rbc_pkg::OPT_W-1:0] option_pins,
  input wire logic size_bit_zero,
  input wire logic processor_side_reset_n_in,
  output logic processor_side_reset_n_out,
  output logic processor_side_reset_n_oe,
  input wire logic primary_side_reset_n_in,
  output logic primary_side_reset_n_out,
  output logic primary_side_reset_n_oe,
  output logic secondary_side_reset_n_out,
  output logic secondary_side_reset_n_oe,
  input wire logic [2:0] bus_request_inputs_n,
  output logic [2:0] arb_request,
  input wire logic cfg_opt_valid,
  input wire logic [rbc_pkg::OPT_W-1:0] cfg_opt_data,
  input wire logic sw_req_en_wr,
  input wire logic [2:0] sw_req_en_data,
  input wire logic sw_tgt_en_wr,
  input wire logic sw_pri_tgt_en,
  input wire logic sw_sec_tgt_en,
  input wire logic sec_bar_programmed,
  input wire logic pb_xfer_start,
  input wire logic pb_agent_is_64,
  output logic pb_agent_reject,
  output logic [2:0] req_enable,
  output logic pri_target_retry,
  output logic sec_target_retry,
  output logic pci1_is_primary,
  output logic pci1_arb_en,
  output logic pci2_arb_en,
  output logic ext_cycles_disable,
  output logic host_mode,
  output logic cfg_from_slave
);

  rbc_sync_if #(.W(rbc_pkg::SY_W)) sy ();

  // The reset, request, strap, size and option pins pass the filter; rst_n and the other inputs do not
  assign sy.raw[rbc_pkg::SY_POR] = power_on_reset_in_n;
  assign sy.raw[rbc_pkg::SY_PRI] = primary_side_reset_n_in;
  assign sy.raw[rbc_pkg::SY_PB] = processor_side_reset_n_in;
  assign sy.raw[rbc_pkg::SY_REQ +: 3] = bus_request_inputs_n;
  assign sy.raw[rbc_pkg::SY_HOST] = host_mode_strap;
  assign sy.raw[rbc_pkg::SY_SIZE0] = size_bit_zero;
  assign sy.raw[rbc_pkg::SY_OPT +: rbc_pkg::OPT_W] = option_pins;

  rbc_pin_filter #(
    .W(rbc_pkg::SY_W),
    .IDLE(rbc_pkg::SY_IDLE)
  ) u_filt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sy(sy)
  );

  logic por_act;
  logic pri_in_act;
  logic pb_in_act;
  logic dev_rst;
  logic [rbc_pkg::OPT_W-1:0] opt_r;
  logic [rbc_pkg::OPT_W-1:0] cfg_word_r;
  logic cfg_seen_r;
  logic hard_act;
  logic hard_act_d_r;
  logic hard_end;
  logic pb_src;
  logic pci_src;
  logic pb_hold_r;
  logic pci_hold_r;
  logic [rbc_pkg::RST_CNT_W-1:0] pb_cnt_r;
  logic [rbc_pkg::RST_CNT_W-1:0] pci_cnt_r;
  logic [rbc_pkg::RST_CNT_W-1:0] hold_val;
  logic [rbc_pkg::OPT_W-1:0] opt_nxt;
  logic [1:0] arb_mode;

  assign por_act = !sy.filt[rbc_pkg::SY_POR];
  assign pri_in_act = !sy.filt[rbc_pkg::SY_PRI];
  assign pb_in_act = !sy.filt[rbc_pkg::SY_PB];
  assign hold_val = rbc_pkg::RST_CNT_W'(HOLD_CYC);
  // Power-on reset clears the enable, request and arbitration flops and sets the retry flops; opt_r, cfg_word_r and cfg_from_slave keep their values
  assign dev_rst = !rst_n || por_act;

  // Strap is caught while power-on reset is held, never by the reset itself
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_mode <= 1'b0;
    end else if (por_act) begin
      host_mode <= sy.filt[rbc_pkg::SY_HOST];
    end
  end

  // Reset sources differ by mode
  assign pb_src = por_act || pri_in_act;
  assign pci_src = por_act || (host_mode ? pb_in_act : pri_in_act);

  // Stretch each reset a minimum time past its source, released on the clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pb_cnt_r <= hold_val;
      pb_hold_r <= 1'b1;
    end else if (pb_src) begin
      pb_cnt_r <= hold_val;
      pb_hold_r <= 1'b1;
    end else if (pb_cnt_r != '0) begin
      pb_cnt_r <= pb_cnt_r - 1'b1;
      pb_hold_r <= 1'b1;
    end else begin
      pb_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pci_cnt_r <= hold_val;
      pci_hold_r <= 1'b1;
    end else if (pci_src) begin
      pci_cnt_r <= hold_val;
      pci_hold_r <= 1'b1;
    end else if (pci_cnt_r != '0) begin
      pci_cnt_r <= pci_cnt_r - 1'b1;
      pci_hold_r <= 1'b1;
    end else begin
      pci_hold_r <= 1'b0;
    end
  end

  // Reset pin drive and direction per mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      processor_side_reset_n_out <= 1'b0;
      processor_side_reset_n_oe <= 1'b1;
      primary_side_reset_n_out <= 1'b0;
      primary_side_reset_n_oe <= 1'b0;
      secondary_side_reset_n_out <= 1'b0;
      secondary_side_reset_n_oe <= 1'b1;
    end else begin
      processor_side_reset_n_out <= !pb_hold_r;
      processor_side_reset_n_oe <= !host_mode;
      primary_side_reset_n_out <= !pci_hold_r;
      primary_side_reset_n_oe <= host_mode;
      secondary_side_reset_n_out <= !(host_mode ? pci_hold_r : pb_hold_r);
      secondary_side_reset_n_oe <= 1'b1;
    end
  end

  // Hard reset seen by the configuration master: our output or, in host mode, the input
  assign hard_act = host_mode ? pb_in_act : pb_hold_r;
  assign hard_end = hard_act_d_r && !hard_act;

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      hard_act_d_r <= 1'b1;
    end else begin
      hard_act_d_r <= hard_act;
    end
  end

  // Options arrive by configuration cycles only inside the hard-reset window
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_seen_r <= 1'b0;
      cfg_word_r <= rbc_pkg::OPT_RST;
    end else if (hard_act && cfg_opt_valid) begin
      cfg_seen_r <= 1'b1;
      cfg_word_r <= cfg_opt_data;
    end else if (hard_end) begin
      cfg_seen_r <= 1'b0;
    end
  end

  // Configuration cycles win over the option pins
  assign opt_nxt = cfg_seen_r ? cfg_word_r : sy.filt[rbc_pkg::SY_OPT +: rbc_pkg::OPT_W];
  assign arb_mode = opt_nxt[rbc_pkg::OPT_ARB_LSB +: 2];

  // Applied options survive until the next hard reset ends
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      opt_r <= rbc_pkg::OPT_RST;
      cfg_from_slave <= 1'b0;
    end else if (hard_end) begin
      opt_r <= opt_nxt;
      cfg_from_slave <= cfg_seen_r;
    end
  end

  // Request recognition: reset from the arbiter option, then software owned
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      req_enable <= rbc_pkg::REQ_EN_NONE;
    end else if (hard_end) begin
      unique case (arb_mode)
        rbc_pkg::ARB_NONE: req_enable <= rbc_pkg::REQ_EN_NONE;
        rbc_pkg::ARB_ONE: req_enable <= rbc_pkg::REQ_EN_ONE;
        default: req_enable <= rbc_pkg::REQ_EN_ALL;
      endcase
    end else if (sw_req_en_wr) begin
      req_enable <= sw_req_en_data;
    end
  end

  // Masked requests toward the arbiter; nothing passes during reset
  always_ff @(posedge core_clk) begin
    if (dev_rst || hard_act) begin
      arb_request <= 3'h0;
    end else begin
      arb_request <= ~sy.filt[rbc_pkg::SY_REQ +: 3] & req_enable;
    end
  end

  // Target access enables follow the retry options, then software
  logic pri_en_r;
  logic sec_en_r;
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      pri_en_r <= 1'b0;
      sec_en_r <= 1'b0;
    end else if (hard_end) begin
      pri_en_r <= !opt_nxt[rbc_pkg::OPT_PRI_RETRY];
      sec_en_r <= !opt_nxt[rbc_pkg::OPT_SEC_RETRY];
    end else if (sw_tgt_en_wr) begin
      pri_en_r <= sw_pri_tgt_en;
      sec_en_r <= sw_sec_tgt_en;
    end
  end

  // Retry while disabled; with its retry option set, the secondary also waits for its base addresses
  always_ff @(posedge core_clk) begin
    if (dev_rst || hard_act) begin
      pri_target_retry <= 1'b1;
      sec_target_retry <= 1'b1;
    end else begin
      pri_target_retry <= !pri_en_r;
      sec_target_retry <= !sec_en_r ||
        (opt_r[rbc_pkg::OPT_SEC_RETRY] && !sec_bar_programmed);
    end
  end

  // Primary choice; the other side owns secondary arbitration, and in host mode both sides arbitrate
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      pci1_is_primary <= 1'b1;
      pci1_arb_en <= 1'b0;
      pci2_arb_en <= 1'b0;
    end else begin
      pci1_is_primary <= opt_r[rbc_pkg::OPT_PCI1_PRI];
      pci1_arb_en <= !opt_r[rbc_pkg::OPT_PCI1_PRI] || host_mode;
      pci2_arb_en <= opt_r[rbc_pkg::OPT_PCI1_PRI] || host_mode;
    end
  end

  // Hardwired size bit forbids extended cycles; agent width check per transfer
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      ext_cycles_disable <= 1'b1;
      pb_agent_reject <= 1'b0;
    end else begin
      ext_cycles_disable <= sy.filt[rbc_pkg::SY_SIZE0];
      pb_agent_reject <= pb_xfer_start && !pb_agent_is_64;
    end
  end

endmodule
`default_nettype wire

/* hw/rbc_pkg.sv */
// Contract
// - A power-up option masks all three processor-bus request inputs until software enables.
// - Another option honours request input 1 only; that master enables inputs 2 and 3.
// - Power-on reset input resets every resource in the device; here opt_r, cfg_word_r and cfg_from_slave are not reset by it.
// - Adapter: processor and secondary resets are outputs, asserted by power-on or primary reset.
// - Host mode: processor reset is input; it drives primary and secondary PCI resets.
// - Optionally retry every primary target access until the processor enables it.
// - Optionally retry secondary target until its base addresses are set and it is enabled.
// - A power-up option selects which PCI interface is primary; the other is secondary.
// - Options latch from configuration cycles run during each hard-reset sequence.
// - Processor-bus interface only talks to agents with a 64-bit port.
// - With size bit zero hardwired, extended transfer cycles stay disabled.
// - The secondary interface generates reset and arbitration for the secondary segment.
// - Options from configuration cycles take precedence over options from system pins.
`default_nettype none
package rbc_pkg;

  // Power-up option word layout
  localparam int OPT_W = 5;
  localparam int OPT_ARB_LSB = 0;
  localparam int OPT_PCI1_PRI = 2;
  localparam int OPT_PRI_RETRY = 3;
  localparam int OPT_SEC_RETRY = 4;
  localparam logic [OPT_W-1:0] OPT_RST = 5'h04;

  // Arbiter start-up modes
  localparam logic [1:0] ARB_ALL = 2'h0;
  localparam logic [1:0] ARB_NONE = 2'h1;
  localparam logic [1:0] ARB_ONE = 2'h2;

  // Request enable values after a hard reset
  localparam logic [2:0] REQ_EN_ALL = 3'h7;
  localparam logic [2:0] REQ_EN_NONE = 3'h0;
  localparam logic [2:0] REQ_EN_ONE = 3'h1;

  // Synchroniser vector layout
  localparam int SY_POR = 0;
  localparam int SY_PRI = 1;
  localparam int SY_PB = 2;
  localparam int SY_REQ = 3;
  localparam int SY_HOST = 6;
  localparam int SY_SIZE0 = 7;
  localparam int SY_OPT = 8;
  localparam int SY_W = 13;
  localparam logic [SY_W-1:0] SY_IDLE = 13'h003f;

  // Reset stretch: least hold after the source goes away
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;

endpackage
`default_nettype wire

/* hw/rbc_sync_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Raw pin levels in, filtered levels out
interface rbc_sync_if #(
  parameter int W = rbc_pkg::SY_W
);
  logic [W-1:0] raw;
  logic [W-1:0] filt;
  modport filt_side (input raw, output filt);
  modport user_side (output raw, input filt);
endinterface
`default_nettype wire

/* hw/rbc_pin_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module rbc_pin_filter #(
  parameter int W = rbc_pkg::SY_W,
  parameter logic [W-1:0] IDLE = rbc_pkg::SY_IDLE
) (
  input wire logic core_clk,
  input wire logic rst_n,
  rbc_sync_if.filt_side sy
);
  // One three-stage chain per pin; the first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic f_r;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        s1_r <= IDLE[i];
        s2_r <= IDLE[i];
        s3_r <= IDLE[i];
      end else begin
        s1_r <= sy.raw[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    // Accept a level only when the last two stages agree, so glitches drop out
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        f_r <= IDLE[i];
      end else if (s2_r == s3_r) begin
        f_r <= s3_r;
      end
    end
    assign sy.filt[i] = f_r;
  end
endmodule
`default_nettype wire

/* hw/rbc_pkg_unused_none.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* verification/rbc_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
// Masters, backplane reset and hard-reset source
module rbc_far_side (
  input wire logic pci_rst,
  input wire logic hard_rst,
  input wire logic [2:0] want,
  input wire logic narrow,
  input wire logic proc_out,
  input wire logic proc_oe,
  input wire logic pri_out,
  input wire logic pri_oe,
  output logic proc_pin,
  output logic pri_pin,
  output logic [2:0] req_n,
  output logic is_64
);
  // Undriven reset lines follow the far-side hard_rst and pci_rst sources
  assign proc_pin = proc_oe ? proc_out : !hard_rst;
  assign pri_pin = pri_oe ? pri_out : !pci_rst;
  assign req_n = ~want;
  assign is_64 = !narrow;
endmodule
`default_nettype wire

/* verification/rbc_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module rbc_top_assertions #(
  parameter int HOLD_CYC = rbc_pkg::RST_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_on_reset_in_n,
  input wire logic size_bit_zero,
  input wire logic processor_side_reset_n_in,
  input wire logic processor_side_reset_n_out,
  input wire logic processor_side_reset_n_oe,
  input wire logic primary_side_reset_n_in,
  input wire logic primary_side_reset_n_out,
  input wire logic primary_side_reset_n_oe,
  input wire logic secondary_side_reset_n_out,
  input wire logic [2:0] arb_request,
  input wire logic sw_req_en_wr,
  input wire logic [2:0] sw_req_en_data,
  input wire logic sw_tgt_en_wr,
  input wire logic sw_pri_tgt_en,
  input wire logic pb_xfer_start,
  input wire logic pb_agent_is_64,
  input wire logic pb_agent_reject,
  input wire logic [2:0] req_enable,
  input wire logic pri_target_retry,
  input wire logic ext_cycles_disable,
  input wire logic host_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // No hard reset in progress, so software writes count
  wire logic up = secondary_side_reset_n_out && processor_side_reset_n_in
    && processor_side_reset_n_out;

  mask_req_a: assert property ((arb_request & ~$past(req_enable)) == 3'h0)
    else $error("request passed while masked");
  req_write_a: assert property (sw_req_en_wr && up
    |=> req_enable == $past(sw_req_en_data)) else $error("request enable write lost");
  tgt_write_a: assert property (sw_tgt_en_wr && sw_pri_tgt_en && up ##1 !sw_tgt_en_wr
    |=> !pri_target_retry) else $error("primary retry kept after enable");
  reject_cause_a: assert property (pb_agent_reject |-> $past(pb_xfer_start))
    else $error("reject without transfer");
  reject_narrow_a: assert property (pb_xfer_start && !pb_agent_is_64
    |=> pb_agent_reject) else $error("narrow agent not rejected");
  mode_oe_a: assert property ($stable(host_mode)[*2]
    |-> processor_side_reset_n_oe != host_mode && primary_side_reset_n_oe == host_mode)
    else $error("reset direction wrong");
  stretch_a: assert property ($rose(secondary_side_reset_n_out)
    |-> $past(secondary_side_reset_n_out, HOLD_CYC) == 1'b0) else $error("reset too short");
  por_all_a: assert property ((!power_on_reset_in_n)[*8] |-> !secondary_side_reset_n_out
    && req_enable == 3'h0 && pri_target_retry) else $error("power-on reset incomplete");
  adapter_rst_a: assert property ((!host_mode && !primary_side_reset_n_in)[*8]
    |-> !processor_side_reset_n_out && !secondary_side_reset_n_out) else $error("adapter reset");
  host_rst_a: assert property ((host_mode && !processor_side_reset_n_in)[*8]
    |-> !primary_side_reset_n_out && !secondary_side_reset_n_out) else $error("host reset");
  ext_off_a: assert property (size_bit_zero[*8] |-> ext_cycles_disable)
    else $error("extended cycles left on");

  // Main scenarios reached
  cover property (sw_tgt_en_wr && up);
  cover property ($rose(secondary_side_reset_n_out) && host_mode);
  cover property (pb_agent_reject);
endmodule
bind rbc_top rbc_top_assertions #(.HOLD_CYC(HOLD_CYC)) u_rbc_top_assertions (.*);
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, power_on_reset_in_n = 1'b0, host_mode_strap = 1'b0;
  logic size_bit_zero = 1'b0, cfg_opt_valid = 1'b0, sw_req_en_wr = 1'b0, sw_tgt_en_wr = 1'b0;
  logic sw_pri_tgt_en = 1'b0, sw_sec_tgt_en = 1'b0, sec_bar_programmed = 1'b0;
  logic pb_xfer_start = 1'b0, pci_rst = 1'b0, hard_rst = 1'b0, narrow = 1'b0;
  logic [rbc_pkg::OPT_W-1:0] option_pins = 5'h04, cfg_opt_data = 5'h00;
  logic [2:0] sw_req_en_data = 3'h0, want = 3'h0;
  wire logic processor_side_reset_n_in, processor_side_reset_n_out, processor_side_reset_n_oe;
  wire logic primary_side_reset_n_in, primary_side_reset_n_out, primary_side_reset_n_oe;
  wire logic secondary_side_reset_n_out, secondary_side_reset_n_oe, pb_agent_is_64;
  wire logic pb_agent_reject, pri_target_retry, sec_target_retry, pci1_is_primary;
  wire logic pci1_arb_en, pci2_arb_en, ext_cycles_disable, host_mode, cfg_from_slave;
  wire logic [2:0] bus_request_inputs_n, arb_request, req_enable;
  int n_fail = 0;
  int total_checks = 0;
  localparam int HOLD = 4;

  // Short hold keeps each boot brief
  rbc_top #(.HOLD_CYC(HOLD)) u_rbc_top (.*);
  rbc_far_side u_rbc_far_side (.pci_rst, .hard_rst, .want, .narrow,
    .proc_out(processor_side_reset_n_out), .proc_oe(processor_side_reset_n_oe),
    .pri_out(primary_side_reset_n_out), .pri_oe(primary_side_reset_n_oe),
    .proc_pin(processor_side_reset_n_in), .pri_pin(primary_side_reset_n_in),
    .req_n(bus_request_inputs_n), .is_64(pb_agent_is_64));

  // 125 MHz
  always #4 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [2:0] exp_req(input logic [1:0] m);
    if (m == rbc_pkg::ARB_NONE) return rbc_pkg::REQ_EN_NONE;
    if (m == rbc_pkg::ARB_ONE) return rbc_pkg::REQ_EN_ONE;
    return rbc_pkg::REQ_EN_ALL;
  endfunction

  // Cold boot; with use_cfg the pins carry the inverse word so a cfg word must win
  task automatic boot(input logic h, input logic use_cfg, input logic [4:0] w);
    int k;
    power_on_reset_in_n <= 1'b0;
    host_mode_strap <= h;
    hard_rst <= h;
    option_pins <= use_cfg ? ~w : w;
    size_bit_zero <= 1'($urandom);
    sec_bar_programmed <= 1'b0;
    want <= 3'h7;
    cyc(12);
    chk(secondary_side_reset_n_out, 1'b0);
    chk(h ? primary_side_reset_n_out : processor_side_reset_n_out, 1'b0);
    cfg_opt_valid <= use_cfg;
    cfg_opt_data <= ~w;
    cyc(1);
    cfg_opt_data <= w;
    cyc(1);
    cfg_opt_valid <= 1'b0;
    power_on_reset_in_n <= 1'b1;
    hard_rst <= 1'b0;
    k = 0;
    while (secondary_side_reset_n_out !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    // Filter latency plus the stretch; a missing stretch would end sooner
    chk(k > HOLD + 4 && k < 300, 1'b1);
    cyc(3);
    chk(req_enable, exp_req(w[1:0]));
    chk(arb_request, exp_req(w[1:0]));
    chk(pci1_is_primary, w[2]);
    chk({pri_target_retry, sec_target_retry}, {w[3], w[4]});
    chk({cfg_from_slave, host_mode}, {use_cfg, h});
    chk({pci1_arb_en, pci2_arb_en}, h ? 2'h3 : {!w[2], w[2]});
    chk(ext_cycles_disable, size_bit_zero);
    chk({processor_side_reset_n_oe, primary_side_reset_n_oe, secondary_side_reset_n_oe},
      {!h, h, 1'b1});
    // Master on input 1 opens the rest, then targets are enabled
    sw_req_en_wr <= 1'b1;
    sw_req_en_data <= 3'h7;
    cyc(1);
    sw_req_en_wr <= 1'b0;
    sw_tgt_en_wr <= 1'b1;
    sw_pri_tgt_en <= 1'b1;
    sw_sec_tgt_en <= 1'b1;
    cyc(1);
    sw_tgt_en_wr <= 1'b0;
    cyc(3);
    chk(arb_request, 3'h7);
    chk({pri_target_retry, sec_target_retry}, {1'b0, w[4]});
    sec_bar_programmed <= 1'b1;
    cyc(3);
    chk(sec_target_retry, 1'b0);
  endtask

  // Main sequence
  initial begin
    void'($urandom(38928));
    cyc(16);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      boot(i[0], i != 5, {3'($urandom), i[1:0]});
    end
    boot(1'b0, 1'b1, 5'($urandom));
    // Backplane reset in adapter mode, then stretch after it
    pci_rst <= 1'b1;
    cyc(12);
    chk({processor_side_reset_n_out, secondary_side_reset_n_out}, 2'h0);
    pci_rst <= 1'b0;
    cyc(9);
    chk(secondary_side_reset_n_out, 1'b0);
    cyc(3);
    chk({processor_side_reset_n_out, secondary_side_reset_n_out}, 2'h3);
    // No cfg word in this window, so the pin word applies
    chk(req_enable, exp_req(option_pins[1:0]));
    chk(cfg_from_slave, 1'b0);
    cyc(30);
    // Transfers from random-width agents, one every other cycle
    for (int j = 0; j < 10; j++) begin
      narrow <= 1'($urandom);
      pb_xfer_start <= 1'b1;
      cyc(1);
      pb_xfer_start <= 1'b0;
      cyc(1);
      chk(pb_agent_reject, narrow);
    end
    cyc(2);
    finish_test;
  end

  // Watchdog well past the expected run
  initial begin
    cyc(8000);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
